// ==== shared/dpc_pkg.sv ====
package dpc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [6:0] REG_PAGE_SEL = 7'h00;
	localparam logic [6:0] REG_OSR_HI = 7'h0d;
	localparam logic [6:0] REG_OSR_LO = 7'h0e;
	localparam logic [6:0] REG_CLIP = 7'h27;
	localparam logic [6:0] REG_BLK_SEL = 7'h3c;
	localparam logic [6:0] REG_BLK_INFO = 7'h3d;
	localparam logic [6:0] REG_BLK_FILT = 7'h3e;
	localparam logic [6:0] REG_POWER = 7'h3f;
	localparam logic [7:0] PAGE_MAIN = 8'h00;
	localparam logic [7:0] PAGE_COEF_LO = 8'h08;
	localparam logic [7:0] PAGE_COEF_HI = 8'h09;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int PWR_LEFT_BIT = 7;
	localparam int PWR_RIGHT_BIT = 6;
	localparam int CLIP_LEFT_BIT = 7;
	localparam int CLIP_RIGHT_BIT = 6;
	localparam int INFO_STEREO_BIT = 7;
	localparam int INFO_IIR_BIT = 6;
	localparam int INFO_BQ_LSB = 3;
	localparam int INFO_BEEP_BIT = 0;
	localparam logic [7:0] OSR_HI_RST = 8'h00;
	localparam logic [7:0] OSR_LO_RST = 8'h80;
	localparam logic [10:0] OSR_ZERO_MEANS = 11'h400;
	localparam logic [4:0] BLK_RST = 5'h01;
	localparam logic [4:0] BLK_FIRST = 5'h01;
	localparam logic [4:0] BLK_LAST = 5'h19;
	localparam logic [4:0] BLK_BEEP = 5'h19;
	localparam logic [2:0] MAX_BIQUADS = 3'h6;

	// ----------------------------------------------------------------
	// Coefficient store: index is {page bit 0, register address}
	// ----------------------------------------------------------------
	localparam logic [7:0] COEF_IIR_LEFT = 8'h82;
	localparam logic [7:0] COEF_IIR_RIGHT = 8'h88;
	localparam logic [7:0] COEF_N1_OFS = 8'h02;
	localparam logic [7:0] COEF_D1_OFS = 8'h04;
	localparam logic [7:0] COEF_UNITY_HI = 8'h7f;
	localparam logic [7:0] COEF_UNITY_LO = 8'hff;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int SAMPLE_RATE_MIN_HZ = 8000;
	localparam int SAMPLE_RATE_MAX_HZ = 192000;
	localparam int SAMPLE_GAP_MIN_CYC = CLK_HZ / SAMPLE_RATE_MAX_HZ;
	localparam int SAMPLE_GAP_MAX_CYC = CLK_HZ / SAMPLE_RATE_MIN_HZ;

	typedef enum logic [1:0] {
		DPC_FILT_A = 2'h0,
		DPC_FILT_B = 2'h1,
		DPC_FILT_C = 2'h2
	} dpc_filt_t;

	// Catalogue entry: [9:8] filter, [7] stereo, [6] first-order IIR,
	// [5:3] biquads, [2] compressor, [1] 3D, [0] tone generator.
	function automatic logic [9:0] blkEntry(input logic [4:0] blk);
		case (blk)
			5'h01: blkEntry = 10'h098;
			5'h02: blkEntry = 10'h0f4;
			5'h03: blkEntry = 10'h0f0;
			5'h04: blkEntry = 10'h018;
			5'h05: blkEntry = 10'h074;
			5'h06: blkEntry = 10'h070;
			5'h07: blkEntry = 10'h1c0;
			5'h08: blkEntry = 10'h1a4;
			5'h09: blkEntry = 10'h1a0;
			5'h0a: blkEntry = 10'h1f4;
			5'h0b: blkEntry = 10'h1f0;
			5'h0c: blkEntry = 10'h140;
			5'h0d: blkEntry = 10'h124;
			5'h0e: blkEntry = 10'h120;
			5'h0f: blkEntry = 10'h174;
			5'h10: blkEntry = 10'h170;
			5'h11: blkEntry = 10'h2c0;
			5'h12: blkEntry = 10'h2e4;
			5'h13: blkEntry = 10'h2e0;
			5'h14: blkEntry = 10'h240;
			5'h15: blkEntry = 10'h264;
			5'h16: blkEntry = 10'h260;
			5'h17: blkEntry = 10'h092;
			5'h18: blkEntry = 10'h0ee;
			5'h19: blkEntry = 10'h0ef;
			default: blkEntry = 10'h000;
		endcase
	endfunction

endpackage

// ==== core/dpc_chan.sv ====
`timescale 1ns/1ps
module dpc_chan (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Configuration
	input wire logic enable,
	input wire logic iirOn,
	input wire dpc_pkg::dpc_filt_t filtType,
	input wire logic [15:0] coefN0,
	input wire logic [15:0] coefN1,
	input wire logic [15:0] coefD1,
	// Sample path
	input wire logic sampleTake,
	input wire logic [15:0] sampleIn,
	input wire logic modStep,
	output logic [3:0] modOut,
	output logic clipPulse
);

	// ----------------------------------------------------------------
	// First-order IIR with saturation
	// ----------------------------------------------------------------
	logic signed [15:0] x1_q;
	logic signed [15:0] y1_q;
	logic signed [15:0] target_q;
	logic signed [15:0] interp_q;
	logic [13:0] err_q;
	logic [3:0] mod_q;
	logic clip_q;

	wire signed [31:0] prodN0 = $signed(sampleIn) * $signed(coefN0);
	wire signed [31:0] prodN1 = x1_q * $signed(coefN1);
	wire signed [31:0] prodD1 = y1_q * $signed(coefD1);
	wire signed [33:0] accSum = 34'(prodN0) + 34'(prodN1) + 34'(prodD1);
	wire accSat = ~((&accSum[33:30]) | ~(|accSum[33:30]));
	wire signed [15:0] satVal = accSum[33] ? 16'sh8000 : 16'sh7fff;
	wire signed [15:0] iirRes = accSat ? satVal : $signed(accSum[30:15]);
	wire signed [15:0] iirOut = iirOn ? iirRes : $signed(sampleIn);
	wire clipNow = (iirOut == 16'sh7fff) || (iirOut == 16'sh8000);

	// ----------------------------------------------------------------
	// Interpolation and modulator
	// ----------------------------------------------------------------
	wire [1:0] interpShift = (filtType == dpc_pkg::DPC_FILT_A) ? 2'h2 :
		(filtType == dpc_pkg::DPC_FILT_B) ? 2'h1 : 2'h0;
	wire signed [16:0] interpDiff = 17'(target_q) - 17'(interp_q);
	wire signed [16:0] interpStep = interpDiff >>> interpShift;
	wire signed [15:0] interpNext = 16'(17'(interp_q) + interpStep);
	wire signed [17:0] modSum = 18'(interp_q) + $signed({4'h0, err_q});

	always_ff @(posedge ref_clk) begin
		if (reset || !enable) begin
			x1_q <= 16'sh0000;
			y1_q <= 16'sh0000;
			target_q <= 16'sh0000;
			interp_q <= 16'sh0000;
			err_q <= 14'h0000;
			mod_q <= 4'h0;
			clip_q <= 1'b0;
		end else begin
			clip_q <= sampleTake && clipNow;
			if (sampleTake) begin
				x1_q <= $signed(sampleIn);
				y1_q <= iirOut;
				target_q <= iirOut;
			end
			if (modStep) begin
				interp_q <= interpNext;
				mod_q <= modSum[17:14];
				err_q <= modSum[13:0];
			end
		end
	end

	assign modOut = mod_q;
	assign clipPulse = clip_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_chan_clip;
		enable && sampleTake && clipNow |=> clipPulse;
	endproperty
	a_chan_clip: assert property (p_chan_clip) else $error("clip not flagged");

	property p_chan_off;
		!enable |=> modOut == 4'h0 && !clipPulse;
	endproperty
	a_chan_off: assert property (p_chan_off) else $error("disabled channel active");

	property p_chan_hold;
		enable && !modStep && !$past(modStep) |=> $stable(modOut);
	endproperty
	a_chan_hold: assert property (p_chan_hold) else $error("modulator moved without step");

endmodule

// ==== core/dpc_core.sv ====
`timescale 1ns/1ps
// Contract
// - Accept and play samples at any rate from 8 kHz to 192 kHz.
// - Oversampling ratio 1 to 1024, split over two page-0 registers.
// - Each channel: processing, interpolation, multibit delta-sigma modulator, analog stage; the core stops at the 4-bit modulator output and has no analog stage.
// - Interpolation filter is one of three types A, B or C.
// - Power bit D7 powers left channel, D6 right, independently; the core enables right only when the selected block is stereo.
// - Left clip flag is read-only bit D7 of the clip register.
// - Right clip flag is read-only bit D6 of the clip register.
// - Selected block fixes processing content and interpolation filter type.
// - Stages offered: first-order IIR, biquads, 3D, tone generator; only the IIR is built, the rest are catalogue flags.
// - IIR and biquad coefficients are host programmable.
// - Catalogue of 25 blocks with given filter and channel modes.
// - At most six biquads; compressor, 3D, tone only in listed blocks.
// - Coefficients cannot be read or written while the DAC runs.
// - Coefficients are 16-bit 1.15 values in two consecutive byte registers.
module dpc_core (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire logic [6:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regRdValid,
	// Audio samples
	input wire logic sampleValid,
	input wire logic [15:0] sampleLeft,
	input wire logic [15:0] sampleRight,
	// Modulator outputs
	output logic modStep,
	output logic [3:0] modOutLeft,
	output logic [3:0] modOutRight,
	// Status
	output logic dacRunning
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] page_q;
	logic [7:0] osrHi_q;
	logic [7:0] osrLo_q;
	logic [7:0] power_q;
	logic [4:0] blkSel_q;
	logic [1:0] clip_q;
	logic [10:0] stepCnt_q;
	logic [7:0] rdData_q;
	logic rdValid_q;
	logic [7:0] coefMem [0:255];
	logic clipLeft;
	logic clipRight;

	// Reset value of a coefficient byte: unity for every N0, else zero.
	function automatic logic [7:0] coefReset(input logic [7:0] idx);
		logic [6:0] a;
		logic [6:0] rel;
		logic n0;
		a = idx[6:0];
		rel = (a >= 7'h42) ? 7'(a - 7'h42) : 7'(a - 7'h02);
		if (idx[7])
			n0 = (a == 7'h02) || (a == 7'h03) || (a == 7'h08) || (a == 7'h09);
		else
			n0 = (a >= 7'h02) && (a <= 7'h7d) && !(a > 7'h3d && a < 7'h42)
				&& ((rel % 7'h0a) < 7'h02);
		coefReset = !n0 ? 8'h00 : (a[0] ? dpc_pkg::COEF_UNITY_LO : dpc_pkg::COEF_UNITY_HI);
	endfunction

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire running = power_q[dpc_pkg::PWR_LEFT_BIT] | power_q[dpc_pkg::PWR_RIGHT_BIT];
	wire pageMain = page_q == dpc_pkg::PAGE_MAIN;
	wire coefPage = (page_q == dpc_pkg::PAGE_COEF_LO) || (page_q == dpc_pkg::PAGE_COEF_HI);
	wire coefAcc = coefPage && (regAddr != dpc_pkg::REG_PAGE_SEL);
	wire [7:0] coefIdx = {page_q[0], regAddr};
	wire wrMain = regWr && pageMain;
	wire wrPage = regWr && (regAddr == dpc_pkg::REG_PAGE_SEL);
	wire wrOsrHi = wrMain && (regAddr == dpc_pkg::REG_OSR_HI) && !running;
	wire wrOsrLo = wrMain && (regAddr == dpc_pkg::REG_OSR_LO) && !running;
	wire wrPower = wrMain && (regAddr == dpc_pkg::REG_POWER);
	wire [9:0] wrEntry = dpc_pkg::blkEntry(regWrData[4:0]);
	wire wrBlk = wrMain && (regAddr == dpc_pkg::REG_BLK_SEL) && !running &&
		(regWrData[7:5] == 3'h0) && (wrEntry != 10'h000);
	wire wrCoef = regWr && coefAcc && !running;
	wire clipClr = regRd && pageMain && (regAddr == dpc_pkg::REG_CLIP);
	wire [9:0] entry = dpc_pkg::blkEntry(blkSel_q);
	wire [1:0] filtBits = entry[9:8];
	wire dpc_pkg::dpc_filt_t filtType = dpc_pkg::dpc_filt_t'(filtBits);
	wire leftEn = power_q[dpc_pkg::PWR_LEFT_BIT];
	wire rightEn = power_q[dpc_pkg::PWR_RIGHT_BIT] && entry[dpc_pkg::INFO_STEREO_BIT];
	wire iirOn = entry[dpc_pkg::INFO_IIR_BIT];
	wire [9:0] osrRaw = {osrHi_q[1:0], osrLo_q};
	wire [10:0] dosrVal = (osrRaw == 10'h000) ? dpc_pkg::OSR_ZERO_MEANS : {1'b0, osrRaw};
	wire powerOff = wrPower && !regWrData[dpc_pkg::PWR_LEFT_BIT] &&
		!regWrData[dpc_pkg::PWR_RIGHT_BIT];
	wire sampleTake = sampleValid && running && !powerOff;
	wire [7:0] clipByte = {clip_q, 6'h00};

	wire [7:0] mainRd = (regAddr == dpc_pkg::REG_OSR_HI) ? osrHi_q :
		(regAddr == dpc_pkg::REG_OSR_LO) ? osrLo_q :
		(regAddr == dpc_pkg::REG_CLIP) ? clipByte :
		(regAddr == dpc_pkg::REG_BLK_SEL) ? {3'h0, blkSel_q} :
		(regAddr == dpc_pkg::REG_BLK_INFO) ? entry[7:0] :
		(regAddr == dpc_pkg::REG_BLK_FILT) ? {6'h00, filtBits} :
		(regAddr == dpc_pkg::REG_POWER) ? power_q : 8'h00;
	wire [7:0] coefRd = running ? 8'h00 : coefMem[coefIdx];
	wire [7:0] rdMux = (regAddr == dpc_pkg::REG_PAGE_SEL) ? page_q :
		pageMain ? mainRd : coefAcc ? coefRd : 8'h00;

	// Each engine word is a byte pair, high byte first, read straight from the store.
	// Plain wires keep the words following later writes, which a called function would not.
	wire [7:0] idxLeftN0 = dpc_pkg::COEF_IIR_LEFT;
	wire [7:0] idxLeftN1 = 8'(dpc_pkg::COEF_IIR_LEFT + dpc_pkg::COEF_N1_OFS);
	wire [7:0] idxLeftD1 = 8'(dpc_pkg::COEF_IIR_LEFT + dpc_pkg::COEF_D1_OFS);
	wire [7:0] idxRightN0 = dpc_pkg::COEF_IIR_RIGHT;
	wire [7:0] idxRightN1 = 8'(dpc_pkg::COEF_IIR_RIGHT + dpc_pkg::COEF_N1_OFS);
	wire [7:0] idxRightD1 = 8'(dpc_pkg::COEF_IIR_RIGHT + dpc_pkg::COEF_D1_OFS);
	wire [15:0] coefLeftN0 = {coefMem[idxLeftN0], coefMem[8'(idxLeftN0 + 8'h01)]};
	wire [15:0] coefLeftN1 = {coefMem[idxLeftN1], coefMem[8'(idxLeftN1 + 8'h01)]};
	wire [15:0] coefLeftD1 = {coefMem[idxLeftD1], coefMem[8'(idxLeftD1 + 8'h01)]};
	wire [15:0] coefRightN0 = {coefMem[idxRightN0], coefMem[8'(idxRightN0 + 8'h01)]};
	wire [15:0] coefRightN1 = {coefMem[idxRightN1], coefMem[8'(idxRightN1 + 8'h01)]};
	wire [15:0] coefRightD1 = {coefMem[idxRightD1], coefMem[8'(idxRightD1 + 8'h01)]};

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			page_q <= dpc_pkg::PAGE_MAIN;
			osrHi_q <= dpc_pkg::OSR_HI_RST;
			osrLo_q <= dpc_pkg::OSR_LO_RST;
			power_q <= 8'h00;
			blkSel_q <= dpc_pkg::BLK_RST;
		end else begin
			if (wrPage)
				page_q <= regWrData;
			if (wrOsrHi)
				osrHi_q <= {6'h00, regWrData[1:0]};
			if (wrOsrLo)
				osrLo_q <= regWrData;
			if (wrPower)
				power_q <= {regWrData[7:6], 6'h00};
			if (wrBlk)
				blkSel_q <= regWrData[4:0];
		end
	end

	// Set wins over the clear-on-read; writes never touch the flags.
	always_ff @(posedge ref_clk) begin
		if (reset)
			clip_q <= 2'h0;
		else
			clip_q <= (clip_q & ~{2{clipClr}}) | {clipLeft, clipRight};
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < 256; i++) begin
				coefMem[i] <= coefReset(8'(i));
			end
		end else if (wrCoef) begin
			coefMem[coefIdx] <= regWrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdData_q <= 8'h00;
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= regRd;
			if (regRd)
				rdData_q <= rdMux;
		end
	end

	// Each sample yields exactly dosrVal modulator steps; a new sample restarts the burst.
	always_ff @(posedge ref_clk) begin
		if (reset || !running || powerOff)
			stepCnt_q <= 11'h000;
		else if (sampleTake)
			stepCnt_q <= dosrVal;
		else if (stepCnt_q != 11'h000)
			stepCnt_q <= stepCnt_q - 11'h001;
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	dpc_chan u_left (
		.ref_clk(ref_clk),
		.reset(reset),
		.enable(leftEn),
		.iirOn(iirOn),
		.filtType(filtType),
		.coefN0(coefLeftN0),
		.coefN1(coefLeftN1),
		.coefD1(coefLeftD1),
		.sampleTake(sampleTake),
		.sampleIn(sampleLeft),
		.modStep(modStep),
		.modOut(modOutLeft),
		.clipPulse(clipLeft)
	);

	dpc_chan u_right (
		.ref_clk(ref_clk),
		.reset(reset),
		.enable(rightEn),
		.iirOn(iirOn),
		.filtType(filtType),
		.coefN0(coefRightN0),
		.coefN1(coefRightN1),
		.coefD1(coefRightD1),
		.sampleTake(sampleTake),
		.sampleIn(sampleRight),
		.modStep(modStep),
		.modOut(modOutRight),
		.clipPulse(clipRight)
	);

	assign modStep = stepCnt_q != 11'h000;
	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;
	assign dacRunning = running;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_osr_load;
		sampleTake |=> stepCnt_q == $past(dosrVal) && modStep;
	endproperty
	a_osr_load: assert property (p_osr_load) else $error("ratio not loaded");

	property p_step_only_running;
		modStep |-> running;
	endproperty
	a_step_only_running: assert property (p_step_only_running) else $error("step while off");

	property p_pwr_left;
		wrPower |=> leftEn == $past(regWrData[dpc_pkg::PWR_LEFT_BIT]);
	endproperty
	a_pwr_left: assert property (p_pwr_left) else $error("left power not applied");

	property p_pwr_right;
		wrPower |=> power_q[dpc_pkg::PWR_RIGHT_BIT] == $past(regWrData[dpc_pkg::PWR_RIGHT_BIT]);
	endproperty
	a_pwr_right: assert property (p_pwr_right) else $error("right power not applied");

	property p_clip_left_ro;
		wrMain && regAddr == dpc_pkg::REG_CLIP && !clipClr && !clipLeft |=> $stable(clip_q[1]);
	endproperty
	a_clip_left_ro: assert property (p_clip_left_ro) else $error("left clip written");

	property p_clip_right_ro;
		wrMain && regAddr == dpc_pkg::REG_CLIP && !clipClr && !clipRight |=> $stable(clip_q[0]);
	endproperty
	a_clip_right_ro: assert property (p_clip_right_ro) else $error("right clip written");

	property p_blk_filter;
		wrBlk |=> filtBits == $past(wrEntry[9:8]) && iirOn == $past(wrEntry[6]);
	endproperty
	a_blk_filter: assert property (p_blk_filter) else $error("block content mismatch");

	property p_blk_range;
		blkSel_q >= dpc_pkg::BLK_FIRST && blkSel_q <= dpc_pkg::BLK_LAST;
	endproperty
	a_blk_range: assert property (p_blk_range) else $error("block out of catalogue");

	property p_blk_resources;
		entry[5:3] <= dpc_pkg::MAX_BIQUADS &&
			(!entry[dpc_pkg::INFO_BEEP_BIT] || blkSel_q == dpc_pkg::BLK_BEEP);
	endproperty
	a_blk_resources: assert property (p_blk_resources) else $error("block resources wrong");

	property p_coef_lock;
		regRd && coefAcc && running |=> regRdData == 8'h00 && regRdValid;
	endproperty
	a_coef_lock: assert property (p_coef_lock) else $error("coefficient read while running");

	property p_cfg_lock;
		running |=> $stable(blkSel_q) && $stable(osrRaw);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("config changed while running");

	property p_mono_right;
		!entry[dpc_pkg::INFO_STEREO_BIT] |=> modOutRight == 4'h0;
	endproperty
	a_mono_right: assert property (p_mono_right) else $error("right active in left-only block");

	c_sample_run: cover property (sampleTake ##1 modStep);
	c_clip_set: cover property (clipLeft ##1 clip_q[1]);
	c_coef_write: cover property (wrCoef);
	c_blk_change: cover property (wrBlk ##1 !entry[dpc_pkg::INFO_STEREO_BIT]);

endmodule

// ==== test/dpc_host_model.sv ====
`timescale 1ns/1ps
module dpc_host_model (
	// Clock
	input wire logic ref_clk,
	// Requests from the bench
	input wire logic fire,
	input wire logic [15:0] fireLeft,
	input wire logic [15:0] fireRight,
	// Sample stream towards the device
	output logic sampleValid,
	output logic [15:0] sampleLeft,
	output logic [15:0] sampleRight
);
	// -----------------------------------------------------------
	// Sample source
	// -----------------------------------------------------------
	// Data means something only with the valid pulse, so between samples the lines show its inverse.
	always @(negedge ref_clk) begin
		sampleValid <= fire;
		sampleLeft <= fire ? fireLeft : ~fireLeft;
		sampleRight <= fire ? fireRight : ~fireRight;
	end
endmodule

// ==== test/dac_processing_chain_config_tb_top.sv ====
`timescale 1ns/1ps
module dac_processing_chain_config_tb_top;
	// -----------------------------------------------------------
	// Signals
	// -----------------------------------------------------------
	logic ref_clk, reset, regWr, regRd, fire, sampleValid, modStep, dacRunning, regRdValid;
	logic [6:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic [15:0] fireLeft, fireRight, sampleLeft, sampleRight;
	logic [3:0] modOutLeft, modOutRight;
	int errTotal = 0;
	int samplesChecked = 0;
	int rightNz = 0;
	int leftNz = 0;
	logic [7:0] expInfo;
	logic [1:0] expFilt;
	logic [2:0] bq;

	dpc_core uut (
		.ref_clk(ref_clk),
		.reset(reset),
		.regAddr(regAddr),
		.regWr(regWr),
		.regRd(regRd),
		.regWrData(regWrData),
		.regRdData(regRdData),
		.regRdValid(regRdValid),
		.sampleValid(sampleValid),
		.sampleLeft(sampleLeft),
		.sampleRight(sampleRight),
		.modStep(modStep),
		.modOutLeft(modOutLeft),
		.modOutRight(modOutRight),
		.dacRunning(dacRunning)
	);

	dpc_host_model host (
		.ref_clk(ref_clk),
		.fire(fire),
		.fireLeft(fireLeft),
		.fireRight(fireRight),
		.sampleValid(sampleValid),
		.sampleLeft(sampleLeft),
		.sampleRight(sampleRight)
	);

	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	task automatic tallyAndFinish();
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regWrData = d;
		regWr = 1'h1;
		@(negedge ref_clk);
		regWr = 1'h0;
	endtask

	// The answer marker and data are both checked in the cycle after the strobe.
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(negedge ref_clk);
		regAddr = a;
		regRd = 1'h1;
		@(negedge ref_clk);
		regRd = 1'h0;
		chk({7'h00, regRdValid, regRdData}, {7'h00, 1'h1, exp});
	endtask

	// Sends one sample pair and counts the modulator steps that follow it.
	task automatic burst(input logic [15:0] l, input logic [15:0] r, input int steps);
		int cnt;
		cnt = 0;
		@(negedge ref_clk);
		fireLeft <= l;
		fireRight <= r;
		fire <= 1'h1;
		@(negedge ref_clk);
		fire <= 1'h0;
		for (int i = 0; i < steps + 4; i++) begin
			@(negedge ref_clk);
			if (modStep === 1'h1) begin
				cnt++;
			end
			if (modOutRight !== 4'h0) begin
				rightNz++;
			end
			if (modOutLeft !== 4'h0) begin
				leftNz++;
			end
		end
		chk(cnt[15:0], steps[15:0]);
		repeat (dpc_pkg::SAMPLE_GAP_MIN_CYC) @(negedge ref_clk);
	endtask

	// -----------------------------------------------------------
	// Clock and watchdog
	// -----------------------------------------------------------
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (40000) @(posedge ref_clk);
		errTotal++;
		tallyAndFinish();
	end

	// -----------------------------------------------------------
	// Tests
	// -----------------------------------------------------------
	initial begin
		reset = 1'h1;
		regAddr = 7'h00;
		regWr = 1'h0;
		regRd = 1'h0;
		regWrData = 8'h00;
		fire = 1'h0;
		fireLeft = 16'h0000;
		fireRight = 16'h0000;
		repeat (20) @(negedge ref_clk);
		reset = 1'h0;
		rd(dpc_pkg::REG_OSR_HI, 8'h00);
		rd(dpc_pkg::REG_OSR_LO, 8'h80);
		rd(dpc_pkg::REG_POWER, 8'h00);
		rd(dpc_pkg::REG_CLIP, 8'h00);
		chk({15'h0000, dacRunning}, 16'h0000);
		// Whole catalogue, expected entries built from the block table.
		for (int b = 1; b <= 25; b++) begin
			expFilt = (b inside {[7:16]}) ? 2'h1 : (b inside {[17:22]}) ? 2'h2 : 2'h0;
			bq = (b inside {7, 12, 17, 20}) ? 3'h0 : (b == 23) ? 3'h2 :
				(b inside {1, 4}) ? 3'h3 : (b inside {24, 25}) ? 3'h5 :
				(b inside {2, 3, 5, 6, 10, 11, 15, 16}) ? 3'h6 : 3'h4;
			expInfo = {b inside {[1:3], [7:11], [17:19], [23:25]},
				!(b inside {1, 4, 8, 9, 13, 14, 23}), bq,
				b inside {2, 5, 8, 10, 13, 15, 18, 21, 24, 25}, b inside {[23:25]}, b == 25};
			wr(dpc_pkg::REG_BLK_SEL, b[7:0]);
			rd(dpc_pkg::REG_BLK_INFO, expInfo);
			rd(dpc_pkg::REG_BLK_FILT, {6'h00, expFilt});
		end
		wr(dpc_pkg::REG_BLK_SEL, 8'h00);
		wr(dpc_pkg::REG_BLK_SEL, 8'h1a);
		wr(dpc_pkg::REG_BLK_SEL, 8'h21);
		rd(dpc_pkg::REG_BLK_SEL, 8'h19);
		// Ratio field width, then the largest ratio.
		wr(dpc_pkg::REG_OSR_HI, 8'hff);
		rd(dpc_pkg::REG_OSR_HI, 8'h03);
		wr(dpc_pkg::REG_OSR_HI, 8'h00);
		wr(dpc_pkg::REG_OSR_LO, 8'h00);
		rd(dpc_pkg::REG_OSR_LO, 8'h00);
		wr(dpc_pkg::REG_POWER, 8'h80);
		chk({15'h0000, dacRunning}, 16'h0001);
		rd(dpc_pkg::REG_POWER, 8'h80);
		burst(16'h1000, 16'h0000, 1024);
		wr(dpc_pkg::REG_POWER, 8'h40);
		rd(dpc_pkg::REG_POWER, 8'h40);
		wr(dpc_pkg::REG_POWER, 8'h00);
		burst(16'h1000, 16'h1000, 0);
		wr(dpc_pkg::REG_OSR_LO, 8'h03);
		// Coefficients while powered down: defaults and write-back.
		wr(dpc_pkg::REG_PAGE_SEL, dpc_pkg::PAGE_COEF_HI);
		rd(7'h02, 8'h7f);
		rd(7'h03, 8'hff);
		wr(7'h04, 8'h7f);
		wr(7'h05, 8'hff);
		wr(7'h0a, 8'h7f);
		wr(7'h0b, 8'hff);
		rd(7'h04, 8'h7f);
		rd(7'h0b, 8'hff);
		wr(dpc_pkg::REG_PAGE_SEL, dpc_pkg::PAGE_MAIN);
		wr(dpc_pkg::REG_BLK_SEL, 8'h07);
		wr(dpc_pkg::REG_POWER, 8'hff);
		rd(dpc_pkg::REG_POWER, 8'hc0);
		// Configuration and coefficients are locked while running.
		wr(dpc_pkg::REG_OSR_LO, 8'h10);
		rd(dpc_pkg::REG_OSR_LO, 8'h03);
		wr(dpc_pkg::REG_BLK_SEL, 8'h09);
		rd(dpc_pkg::REG_BLK_SEL, 8'h07);
		wr(dpc_pkg::REG_PAGE_SEL, dpc_pkg::PAGE_COEF_HI);
		rd(7'h04, 8'h00);
		wr(7'h04, 8'h00);
		wr(dpc_pkg::REG_PAGE_SEL, dpc_pkg::PAGE_MAIN);
		// Left saturation, clear on read, write ignored, then right saturation.
		burst(16'h7fff, 16'h0000, 3);
		burst(16'h7fff, 16'h0000, 3);
		rd(dpc_pkg::REG_CLIP, 8'h80);
		rd(dpc_pkg::REG_CLIP, 8'h00);
		wr(dpc_pkg::REG_CLIP, 8'hff);
		rd(dpc_pkg::REG_CLIP, 8'h00);
		burst(16'h0000, 16'h0000, 3);
		burst(16'h0000, 16'h7fff, 3);
		burst(16'h0000, 16'h7fff, 3);
		rd(dpc_pkg::REG_CLIP, 8'h40);
		// Filter C stereo block, then a left-only block keeps the right modulator silent.
		wr(dpc_pkg::REG_POWER, 8'h00);
		wr(dpc_pkg::REG_BLK_SEL, 8'h11);
		wr(dpc_pkg::REG_POWER, 8'hc0);
		burst(16'h4000, 16'h4000, 3);
		wr(dpc_pkg::REG_POWER, 8'h00);
		wr(dpc_pkg::REG_BLK_SEL, 8'h0c);
		wr(dpc_pkg::REG_POWER, 8'hc0);
		rightNz = 0;
		leftNz = 0;
		burst(16'h4000, 16'h4000, 3);
		burst(16'h4000, 16'h4000, 3);
		chk(rightNz[15:0], 16'h0000);
		chk({15'h0000, leftNz != 0}, 16'h0001);
		wr(dpc_pkg::REG_POWER, 8'h00);
		wr(dpc_pkg::REG_PAGE_SEL, dpc_pkg::PAGE_COEF_HI);
		rd(7'h04, 8'h7f);
		wr(dpc_pkg::REG_PAGE_SEL, dpc_pkg::PAGE_MAIN);
		rd(7'h50, 8'h00);
		tallyAndFinish();
	end
endmodule
